/* hw/eeprom_command_control.sv */
// Software command interface of the serial EEPROM controller: command,
// data, interrupt and loader registers behind AXI4-Lite.
// Assumes a serial engine and a configuration loader on CORE_CLK that
// answer with one-cycle done, timeout and overflow pulses.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module eeprom_command_control
  import eeprom_cmd_pkg::*;
#(
  parameter int ADDR_FIELD_W = 16,
  parameter int AXI_ADDR_W = 12,
  parameter int WATCHDOG_CYCLES = 65536
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic CORE_CE,
  input wire logic DIGITAL_RST,
  input wire logic [AXI_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [AXI_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic OP_START,
  output logic [CODE_W-1:0] OP_CODE,
  output logic [ADDR_FIELD_W-1:0] OP_ADDR,
  output logic [DATA_W-1:0] OP_WDATA,
  output logic THREE_WIRE,
  input wire logic OP_DONE,
  input wire logic [DATA_W-1:0] OP_RDATA,
  input wire logic OP_TIMEOUT,
  output logic LOADER_START,
  input wire logic LOADER_DONE,
  input wire logic LOADER_OVERFLOW,
  output logic IRQ
);

  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  // The address field must fit below the command field
  if (ADDR_FIELD_W < 1 || ADDR_FIELD_W > CODE_LSB) begin : g_bad_addr_w
    $error("ADDR_FIELD_W must lie between 1 and 28");
  end
  if (AXI_ADDR_W < 12) begin : g_bad_axi_w
    $error("AXI_ADDR_W must be at least 12 to reach the map");
  end
  if (WATCHDOG_CYCLES < 2) begin : g_bad_wd
    $error("WATCHDOG_CYCLES must be at least 2");
  end

  typedef enum logic [1:0] {
    ST_LOAD,
    ST_IDLE,
    ST_RUN
  } state_t;

  localparam int WD_W = $clog2(WATCHDOG_CYCLES + 1);
  localparam logic [WD_W-1:0] WD_LIMIT = WD_W'(WATCHDOG_CYCLES - 1);

  state_t state;
  logic busy;
  logic [CODE_W-1:0] op_code;
  logic [ADDR_FIELD_W-1:0] target;
  logic [DATA_W-1:0] byte_data;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic three_wire;
  logic loader_overflow;
  logic loader_done_flag;
  logic [WD_W-1:0] wd_count;

  logic wr_en;
  logic [AXI_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [AXI_ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;

  logic cmd_hit;
  logic data_hit;
  logic sts_hit;
  logic mask_hit;
  logic cfg_hit;
  logic start;
  logic [CODE_W-1:0] next_code;
  logic unsupported;
  logic run_end;
  logic wd_expired;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] irq_clear;

  // ---------------------------------------------------------------
  // Bus front end
  // ---------------------------------------------------------------
  axil_reg_port #(
    .ADDR_W(AXI_ADDR_W)
  ) u_port (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .ce(CORE_CE),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  // Only the low twelve address bits select a register
  assign cmd_hit = wr_en && wr_addr[11:0] == CMD_OFF;
  assign data_hit = wr_en && wr_addr[11:0] == DATA_OFF;
  assign sts_hit = wr_en && wr_addr[11:0] == IRQ_STS_OFF;
  assign mask_hit = wr_en && wr_addr[11:0] == IRQ_MASK_OFF;
  assign cfg_hit = wr_en && wr_addr[11:0] == CFG_OFF;
  assign wr_ok = cmd_hit | data_hit | sts_hit | mask_hit | cfg_hit
    | (wr_addr[11:0] == LOADER_STS_OFF);

  // Code seen by a start: the written one if its lane is enabled
  assign next_code = wr_strb[STRB_CODE_LANE] ?
    wr_data[CODE_LSB +: CODE_W] : op_code;
  assign start = cmd_hit && wr_strb[STRB_CODE_LANE]
    && wr_data[BUSY_BIT] && state == ST_IDLE;
  // Two-wire mode cannot disable, enable, write all or erase
  assign unsupported = !three_wire && next_code != OP_READ
    && next_code != OP_WRITE && next_code != OP_RELOAD;

  // A run ends on the engine's answer or on the watchdog
  assign wd_expired = wd_count == WD_LIMIT;
  assign run_end = state == ST_RUN && (OP_DONE || OP_TIMEOUT || wd_expired);

  // ---------------------------------------------------------------
  // Sequencer and busy flag
  // ---------------------------------------------------------------
  // Busy is a plain flop so the readback never glitches between states
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state <= ST_LOAD;
      busy <= 1'b1;
      OP_START <= 1'b0;
      LOADER_START <= 1'b0;
    end else if (CORE_CE) begin
      OP_START <= 1'b0;
      LOADER_START <= 1'b0;
      if (DIGITAL_RST) begin
        state <= ST_LOAD;
        busy <= 1'b1;
        LOADER_START <= 1'b1;
      end else begin
        unique case (state)
          ST_LOAD: begin
            if (LOADER_DONE) begin
              state <= ST_IDLE;
              busy <= 1'b0;
            end
          end
          ST_IDLE: begin
            if (start && unsupported) begin
              busy <= 1'b0;
            end else if (start && next_code == OP_RELOAD) begin
              state <= ST_LOAD;
              busy <= 1'b1;
              LOADER_START <= 1'b1;
            end else if (start) begin
              state <= ST_RUN;
              busy <= 1'b1;
              OP_START <= 1'b1;
            end
          end
          ST_RUN: begin
            if (run_end) begin
              state <= ST_IDLE;
              busy <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // No-response watchdog
  // ---------------------------------------------------------------
  // Backstop in case the engine never answers; ends the run as a timeout
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      wd_count <= '0;
    end else if (CORE_CE) begin
      if (state == ST_RUN && !run_end) begin
        wd_count <= wd_count + WD_W'(1);
      end else begin
        wd_count <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Command fields
  // ---------------------------------------------------------------
  // Host writes change fields only while idle, so a running command stays intact; digital reset clears them in any state
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      op_code <= CODE_RESET;
      target <= '0;
    end else if (CORE_CE) begin
      if (DIGITAL_RST) begin
        op_code <= CODE_RESET;
        target <= '0;
      end else if (cmd_hit && state == ST_IDLE) begin
        if (wr_strb[STRB_CODE_LANE]) begin
          op_code <= wr_data[CODE_LSB +: CODE_W];
        end
        for (int i = 0; i < ADDR_FIELD_W; i++) begin
          if (wr_strb[i / 8]) begin
            target[i] <= wr_data[i];
          end
        end
      end
    end
  end

  assign OP_CODE = op_code;
  assign OP_ADDR = target;

  // ---------------------------------------------------------------
  // Data byte
  // ---------------------------------------------------------------
  // Read results land on the same edge that busy drops
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      byte_data <= DATA_RESET;
    end else if (CORE_CE) begin
      if (DIGITAL_RST) begin
        byte_data <= DATA_RESET;
      end else if (state == ST_RUN && OP_DONE && op_code == OP_READ) begin
        byte_data <= OP_RDATA;
      end else if (data_hit && wr_strb[0] && state == ST_IDLE) begin
        byte_data <= wr_data[DATA_W-1:0];
      end
    end
  end

  assign OP_WDATA = byte_data;

  // ---------------------------------------------------------------
  // Configuration and loader status
  // ---------------------------------------------------------------
  // Mode changes mid-command would confuse the engine: idle only
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      three_wire <= THREE_WIRE_RESET;
    end else if (CORE_CE) begin
      if (cfg_hit && wr_strb[0] && state == ST_IDLE) begin
        three_wire <= wr_data[CFG_THREE_WIRE_BIT];
      end
    end
  end

  assign THREE_WIRE = three_wire;

  // Overflow set wins over a clear arriving in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      loader_overflow <= 1'b0;
      loader_done_flag <= 1'b0;
    end else if (CORE_CE) begin
      if (LOADER_OVERFLOW) begin
        loader_overflow <= 1'b1;
      end else if (DIGITAL_RST || LOADER_START) begin
        loader_overflow <= 1'b0;
      end
      if (LOADER_DONE) begin
        loader_done_flag <= 1'b1;
      end else if (DIGITAL_RST || LOADER_START) begin
        loader_done_flag <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  // Unsupported codes report as a timeout, like a missing device
  always_comb begin
    events = '0;
    events[IRQ_DONE_BIT] = state == ST_RUN && OP_DONE;
    events[IRQ_TIMEOUT_BIT] = (state == ST_RUN && (OP_TIMEOUT || wd_expired))
      || (start && unsupported);
    events[IRQ_LOADED_BIT] = state == ST_LOAD && LOADER_DONE && !DIGITAL_RST;
  end

  assign irq_clear = (sts_hit && wr_strb[0]) ? wr_data[IRQ_W-1:0] : '0;

  // Write one to clear; a new event in the same cycle is kept
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      irq_status <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
      IRQ <= 1'b0;
    end else if (CORE_CE) begin
      irq_status <= (irq_status & ~irq_clear) | events;
      if (mask_hit && wr_strb[0]) begin
        irq_mask <= wr_data[IRQ_W-1:0];
      end
      IRQ <= |(((irq_status & ~irq_clear) | events) & irq_mask);
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_data = '0;
    rd_ok = 1'b1;
    unique case (rd_addr[11:0])
      CMD_OFF: begin
        rd_data[BUSY_BIT] = busy;
        rd_data[CODE_LSB +: CODE_W] = op_code;
        rd_data[ADDR_FIELD_W-1:0] = target;
      end
      DATA_OFF: rd_data[DATA_W-1:0] = byte_data;
      IRQ_STS_OFF: rd_data[IRQ_W-1:0] = irq_status;
      IRQ_MASK_OFF: rd_data[IRQ_W-1:0] = irq_mask;
      CFG_OFF: rd_data[CFG_THREE_WIRE_BIT] = three_wire;
      LOADER_STS_OFF: begin
        rd_data[LDR_DONE_BIT] = loader_done_flag;
        rd_data[LDR_OVERFLOW_BIT] = loader_overflow;
      end
      default: rd_ok = 1'b0;
    endcase
  end

endmodule // eeprom_command_control

/* common/eeprom_cmd_pkg.sv */
// Register map, field layout, command codes and reset values of the
// EEPROM command block. Assumes a 32-bit AXI4-Lite register bus.
//
// Behaviour
// - Writing one to busy (bit 31) starts the operation in the code field at the stored address.
// - The busy bit stays at one for the whole operation and clears by itself when it finishes.
// - After a read, busy returning to zero means the data register holds the fetched byte.
// - A write with no EEPROM keeps busy set until the timeout flag sets, and then busy clears.
// - Busy is forced to one after power-up, after pin reset and after a software digital reset.
// - After a reset busy clears only when the loader has finished, so host commands wait.
// - Code resets to 000: 000 read, 001 disable, 010 enable, 011 write, 100 write all, 101 erase.
// - 110 erases all, 111 reloads; erase, write all, enable and disable need three-wire mode.
// - The loader overflow flag is cleared when a reload restarts the loader or on digital reset.
package eeprom_cmd_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] CMD_OFF = 12'h1b4;
  localparam logic [11:0] DATA_OFF = 12'h1b8;
  localparam logic [11:0] IRQ_STS_OFF = 12'h1bc;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h1c0;
  localparam logic [11:0] CFG_OFF = 12'h1c4;
  localparam logic [11:0] LOADER_STS_OFF = 12'h1c8;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BUSY_BIT = 31;
  localparam int CODE_LSB = 28;
  localparam int CODE_W = 3;
  localparam int DATA_W = 8;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_TIMEOUT_BIT = 1;
  localparam int IRQ_LOADED_BIT = 2;
  localparam int CFG_THREE_WIRE_BIT = 0;
  localparam int LDR_DONE_BIT = 0;
  localparam int LDR_OVERFLOW_BIT = 18;
  localparam int STRB_CODE_LANE = 3;

  // ---------------------------------------------------------------
  // Reset values and bus answers
  // ---------------------------------------------------------------
  localparam logic [2:0] CODE_RESET = 3'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam logic THREE_WIRE_RESET = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operation codes of the command field
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_ERASE_WRITE_DISABLE = 3'h1,
    OP_ERASE_WRITE_ENABLE = 3'h2,
    OP_WRITE = 3'h3,
    OP_WRITE_ALL_LOCATIONS = 3'h4,
    OP_ERASE = 3'h5,
    OP_ERASE_ALL_LOCATIONS = 3'h6,
    OP_RELOAD = 3'h7
  } op_code_t;

endpackage

/* hw/axil_reg_port.sv */
// AXI4-Lite slave front end: turns bus transfers into one-cycle
// register write strobes and a direct read address. Assumes a core on the same clock.
`timescale 1ns/1ps
module axil_reg_port
  import eeprom_cmd_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  logic aw_held;
  logic w_held;

  // Strobe fires once both halves of a write are in and no answer waits
  assign wr_en = ce & aw_held & w_held & ~bvalid;
  assign rd_addr = araddr;

  // ---------------------------------------------------------------
  // Write channels
  // ---------------------------------------------------------------
  // Address and data are taken in either order and held until used
  always_ff @(posedge clk) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_held <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_en) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR; // Unmapped: error
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read channels
  // ---------------------------------------------------------------
  // Data is sampled at the address handshake, so reads take one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_ok ? rd_data : 32'h0000_0000;
        rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule // axil_reg_port

/* verification/eeprom_engine_model.sv */
// Far side model: serial engine and configuration loader.
// Assumes the command block's engine pins on the same clock.
`timescale 1ns/1ps
module eeprom_engine_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic op_start,
  input wire logic [15:0] op_addr,
  input wire logic loader_start,
  input wire logic absent,
  input wire logic slow,
  input wire logic ovf_en,
  output logic op_done,
  output logic [7:0] op_rdata,
  output logic op_timeout,
  output logic loader_done,
  output logic loader_ovf
);
  logic [3:0] op_cnt = 4'h0;
  logic [3:0] ld_cnt = 4'h0;
  logic [7:0] addr_q = 8'h00;
  logic [7:0] noise = 8'h00;
  // Engine: one answer per start; slow stays under the watchdog
  always_ff @(posedge clk) begin
    noise <= noise + 8'h3b;
    op_done <= 1'b0;
    op_timeout <= 1'b0;
    if (rst) begin
      op_cnt <= 4'h0;
    end else if (op_start) begin
      op_cnt <= slow ? 4'ha : 4'h2;
      addr_q <= op_addr[7:0];
    end else if (op_cnt == 4'h1) begin
      op_cnt <= 4'h0;
      op_done <= !absent;
      op_timeout <= absent;
    end else if (op_cnt != 4'h0) begin
      op_cnt <= op_cnt - 4'h1;
    end
  end
  // Byte is valid only with done; churns otherwise so stale use shows
  assign op_rdata = op_done ? (addr_q ^ 8'h5a) : noise;
  // Loader runs after reset release or on request
  always_ff @(posedge clk) begin
    loader_done <= 1'b0;
    loader_ovf <= 1'b0;
    if (rst || loader_start) begin
      ld_cnt <= 4'ha;
    end else if (ld_cnt == 4'h1) begin
      ld_cnt <= 4'h0;
      loader_done <= 1'b1;
      loader_ovf <= ovf_en;
    end else if (ld_cnt != 4'h0) begin
      ld_cnt <= ld_cnt - 4'h1;
    end
  end
endmodule // eeprom_engine_model

/* verification/eeprom_command_control_monitor.sv */
// Concurrent checks on the EEPROM command block's pins.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module eeprom_command_control_monitor (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic DIGITAL_RST,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic OP_START,
  input wire logic OP_DONE,
  input wire logic OP_TIMEOUT,
  input wire logic LOADER_START,
  input wire logic LOADER_DONE
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SYS_RST);
  logic loaded;
  logic running;
  // Loader finished since the last reset of either kind
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || DIGITAL_RST) begin
      loaded <= 1'b0;
    end else if (LOADER_DONE) begin
      loaded <= 1'b1;
    end
  end
  // Engine busy as seen at the pins
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || OP_DONE || OP_TIMEOUT) begin
      running <= 1'b0;
    end else if (OP_START) begin
      running <= 1'b1;
    end
  end
  sequence s_b_wait;
    S_AXI_BVALID && !S_AXI_BREADY;
  endsequence
  sequence s_r_wait;
    S_AXI_RVALID && !S_AXI_RREADY;
  endsequence
  sequence s_restart;
    DIGITAL_RST ##1 LOADER_START;
  endsequence
  a_start_pulse: assert property (OP_START |=> !OP_START)
    else $error("start longer than one cycle");
  a_start_gated: assert property (OP_START |-> loaded && !running)
    else $error("start while busy");
  a_reload_pulse: assert property (LOADER_START |=> !LOADER_START)
    else $error("loader start too long");
  a_dreset_restart: assert property ($rose(DIGITAL_RST) |-> s_restart)
    else $error("no loader restart");
  a_bresp_hold: assert property (s_b_wait |=> S_AXI_BVALID)
    else $error("write answer dropped");
  a_rresp_hold: assert property (s_r_wait |=> S_AXI_RVALID)
    else $error("read answer dropped");
  a_aw_closed: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("write taken during answer");
  a_ar_closed: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken during answer");
endmodule // eeprom_command_control_monitor
bind eeprom_command_control eeprom_command_control_monitor i_eeprom_command_control_monitor (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .DIGITAL_RST(DIGITAL_RST),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .OP_START(OP_START), .OP_DONE(OP_DONE), .OP_TIMEOUT(OP_TIMEOUT),
  .LOADER_START(LOADER_START), .LOADER_DONE(LOADER_DONE)
);

/* verification/test_eeprom_command_control.sv */
// Self-checking bench of the EEPROM command block.
// Assumes the engine model on the far side and AXI4-Lite tasks here.
`timescale 1ns/1ps
module test_eeprom_command_control import eeprom_cmd_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, drst = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, op_start, three_wire, irq;
  logic [1:0] bresp, rresp, rresp_q;
  logic [2:0] op_code;
  logic [15:0] op_addr;
  logic [7:0] op_wdata, op_rdata;
  logic op_done, op_timeout, loader_start, loader_done, loader_ovf;
  logic absent = 1'b0, slow = 1'b0, ovf_en = 1'b1;
  int fail_count = 0, n_tests = 0, starts = 0;
  // Clock and engine start counter
  always #20 clk = ~clk;
  always @(posedge clk) if (op_start === 1'b1) starts <= starts + 1;
  eeprom_command_control #(.WATCHDOG_CYCLES(16)) i_eeprom_command_control (
    .CORE_CLK(clk), .SYS_RST(rst), .CORE_CE(1'b1), .DIGITAL_RST(drst),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .OP_START(op_start), .OP_CODE(op_code), .OP_ADDR(op_addr), .OP_WDATA(op_wdata),
    .THREE_WIRE(three_wire), .OP_DONE(op_done), .OP_RDATA(op_rdata),
    .OP_TIMEOUT(op_timeout), .LOADER_START(loader_start), .LOADER_DONE(loader_done),
    .LOADER_OVERFLOW(loader_ovf), .IRQ(irq));
  eeprom_engine_model i_eeprom_engine_model (
    .clk(clk), .rst(rst), .op_start(op_start), .op_addr(op_addr),
    .loader_start(loader_start), .absent(absent), .slow(slow), .ovf_en(ovf_en),
    .op_done(op_done), .op_rdata(op_rdata), .op_timeout(op_timeout),
    .loader_done(loader_done), .loader_ovf(loader_ovf));
  task automatic end_of_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Bus master: hold each channel until its own handshake edge
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awv && awready) awv <= 1'b0;
      if (wv && wready) wv <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    chk({31'h0, bvalid}, 32'h1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, RESP_OKAY});
  endtask
  task automatic axr(input logic [11:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arv && arready) arv <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    chk({31'h0, rvalid}, 32'h1);
    d = rdata;
    rresp_q = rresp;
    rready <= 1'b0;
  endtask
  // Poll busy before anything new is issued
  task automatic wait_idle();
    logic [31:0] d;
    int n;
    n = 0;
    do begin
      axr(CMD_OFF, d);
      n++;
    end while (d[31] !== 1'b0 && n < 40);
    chk(d & 32'h8000_0000, 32'h0);
  endtask
  task automatic t_reset();
    logic [31:0] d;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    axr(CMD_OFF, d);
    chk({28'h0, d[31:28]}, 32'h8);
    wait_idle();
    axr(LOADER_STS_OFF, d);
    chk(d & 32'h40000, 32'h40000);
    axr(12'h000, d);
    chk({30'h0, rresp_q}, {30'h0, RESP_SLVERR});
  endtask
  task automatic t_read();
    logic [31:0] d;
    slow <= 1'b1;
    axw(CMD_OFF, 32'h8000_0123);
    chk({13'h0, op_code, op_addr}, {13'h0, OP_READ, 16'h0123});
    axr(CMD_OFF, d);
    chk(d & 32'h8000_0000, 32'h8000_0000);
    axw(CMD_OFF, 32'h3000_0456);
    wait_idle();
    axr(CMD_OFF, d);
    chk(d & 32'h7000_ffff, 32'h0000_0123);
    axr(DATA_OFF, d);
    chk(d, 32'h0000_0079);
    slow <= 1'b0;
  endtask
  task automatic t_irq();
    absent <= 1'b1;
    chk({31'h0, irq}, 32'h0);
    axw(IRQ_MASK_OFF, 32'h0000_0002);
    axw(CMD_OFF, 32'hb000_0010);
    wait_idle();
    chk({31'h0, irq}, 32'h1);
    axw(IRQ_STS_OFF, 32'h0000_0007);
    chk({31'h0, irq}, 32'h0);
    absent <= 1'b0;
  endtask
  task automatic t_codes();
    int s0;
    s0 = starts;
    for (int c = 1; c < 7; c++) begin
      if (c != 3) axw(CMD_OFF, {1'b1, 3'(c), 28'h0});
    end
    chk(32'(starts - s0), 32'h0);
    chk({31'h0, irq}, 32'h1);
    axw(DATA_OFF, 32'h0000_00a6);
    chk({24'h0, op_wdata}, 32'h0000_00a6);
    axw(CFG_OFF, 32'h0000_0001);
    chk({31'h0, three_wire}, 32'h1);
    for (int c = 1; c < 7; c++) begin
      axw(CMD_OFF, {1'b1, 3'(c), 28'h0});
      chk({29'h0, op_code}, 32'(c));
      wait_idle();
    end
    chk(32'(starts - s0), 32'h6);
  endtask
  task automatic t_reload();
    logic [31:0] d;
    ovf_en <= 1'b0;
    axw(CMD_OFF, 32'hf000_0000);
    axr(CMD_OFF, d);
    chk(d & 32'h8000_0000, 32'h8000_0000);
    wait_idle();
    axr(LOADER_STS_OFF, d);
    chk(d & 32'h40000, 32'h0);
    drst <= 1'b1;
    @(posedge clk);
    drst <= 1'b0;
    axr(CMD_OFF, d);
    chk(d & 32'h8000_0000, 32'h8000_0000);
    wait_idle();
  endtask
  // Main sequence and hang guard
  initial begin
    t_reset();
    t_read();
    t_irq();
    t_codes();
    t_reload();
    end_of_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
endmodule // test_eeprom_command_control
